// >>> src/lrs_sequencer.sv
// Notes on behaviour
// - one full refresh takes exactly 512 refresh-clock cycles, then repeats
// - eight row drivers enabled strictly in turn, only one at a time
// - each row owns a 64-cycle slot; eight slots form the refresh
// - four blank cycles start each slot; row lit at most 60 cycles
// - 160 dots as 20 columns by 8 rows; active row drives columns
// - at most 20 LEDs lit at once, one row's columns only
// - brightness set by on-cycles per row within the 64-cycle slot
// - on-time and peak current come from separate inputs, each registered
// - refresh counters run on sys_clk_i, stepped by internal or external oscillator ticks
// - prescaler bit high divides external oscillator by 8, low passes
// - prescaler acts only on the external path, never internal
`timescale 1ns/10ps
module lrs_sequencer (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic int_osc_tick_i,
	input wire logic ext_osc_tick_i,
	input wire logic ext_osc_select_i,
	input wire logic ext_clock_divider_select_i,
	input wire logic [lrs_pkg::ONT_W-1:0] on_cycles_i,
	input wire logic [lrs_pkg::PEAK_W-1:0] peak_current_i,
	input wire logic [lrs_pkg::DOTS-1:0] dots_i,
	output logic [lrs_pkg::ROWS-1:0] row_sink_o,
	output logic [lrs_pkg::COLS-1:0] col_src_o,
	output logic [lrs_pkg::PEAK_W-1:0] peak_current_o,
	output logic [lrs_pkg::ROW_W-1:0] row_index_o,
	output logic refresh_start_o
);
	import lrs_pkg::*;

	// prescaler and tick select
	logic [PRE_W-1:0] pre_q;
	logic [PRE_W-1:0] pre_d;
	logic ext_wrap;
	logic ext_tick;
	logic tick;

	// slot and row counters
	logic [SLOT_W-1:0] slot_q;
	logic [SLOT_W-1:0] slot_d;
	logic [ROW_W-1:0] row_q;
	logic [ROW_W-1:0] row_d;
	logic slot_wrap;
	logic row_wrap;

	// refresh start pulse
	logic start_q;
	logic start_d;

	// brightness settings
	logic [ONT_W-1:0] ont_q;
	logic [ONT_W-1:0] ont_d;
	logic [PEAK_W-1:0] peak_q;
	logic [PEAK_W-1:0] peak_d;

	// lit window
	lrs_phase_t phase;
	logic [SLOT_W:0] lit_pos;
	logic lit;

	// row decoder and column multiplexers
	logic [ROWS-1:0] row_hit;
	logic [COLS-1:0] col_pick;

	// output stage
	logic [ROWS-1:0] sink_q;
	logic [ROWS-1:0] sink_d;
	logic [COLS-1:0] col_q;
	logic [COLS-1:0] col_d;

	// divide by eight on external ticks only
	always_comb begin
		pre_d = pre_q;
		ext_wrap = (pre_q == PRE_LAST);
		if (ext_osc_tick_i && ext_clock_divider_select_i) begin
			if (ext_wrap) begin
				pre_d = PRE_RST;
			end else begin
				pre_d = pre_q + 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pre_q <= PRE_RST;
		end else begin
			pre_q <= pre_d;
		end
	end

	// refresh tick from the selected source
	always_comb begin
		ext_tick = 1'b0;
		if (ext_osc_tick_i) begin
			if (ext_clock_divider_select_i) begin
				ext_tick = ext_wrap;
			end else begin
				ext_tick = 1'b1;
			end
		end
		// internal tick never passes the prescaler
		tick = ext_osc_select_i ? ext_tick : int_osc_tick_i;
	end

	// slot within the row, row within the refresh
	always_comb begin
		slot_wrap = (slot_q == SLOT_LAST);
		row_wrap = (row_q == ROW_LAST);
		slot_d = slot_q;
		row_d = row_q;
		if (tick) begin
			if (slot_wrap) begin
				slot_d = SLOT_RST;
				if (row_wrap) begin
					row_d = ROW_RST;
				end else begin
					row_d = row_q + 3'h1;
				end
			end else begin
				slot_d = slot_q + 6'h01;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			slot_q <= SLOT_RST;
			row_q <= ROW_RST;
		end else begin
			slot_q <= slot_d;
			row_q <= row_d;
		end
	end

	// one pulse as the last row hands over to the first
	always_comb begin
		start_d = tick && slot_wrap && row_wrap;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			start_q <= 1'b0;
		end else begin
			start_q <= start_d;
		end
	end

	// on-time capped at sixty, peak code alongside
	always_comb begin
		if (on_cycles_i > ON_MAX) begin
			ont_d = ON_MAX;
		end else begin
			ont_d = on_cycles_i;
		end
		peak_d = peak_current_i;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ont_q <= '0;
			peak_q <= '0;
		end else begin
			ont_q <= ont_d;
			peak_q <= peak_d;
		end
	end

	// blanking at slot start, then the on-time window
	always_comb begin
		phase = (slot_q < BLANK_CYC) ? LRS_BLANK : LRS_LIT;
		lit_pos = {1'b0, slot_q} - {1'b0, BLANK_CYC};
		lit = 1'b0;
		unique case (phase)
			LRS_BLANK: begin
				lit = 1'b0;
			end
			LRS_LIT: begin
				lit = (lit_pos < {1'b0, ont_q});
			end
		endcase
	end

	// one-of-eight row decoder
	for (genvar r = 0; r < ROWS; r++) begin : g_row
		assign row_hit[r] = (row_q == ROW_W'(r));
	end

	// eight-to-one multiplexer per column, selected by the row
	for (genvar c = 0; c < COLS; c++) begin : g_col
		logic [ROWS-1:0] col_bits;
		for (genvar r = 0; r < ROWS; r++) begin : g_bit
			assign col_bits[r] = dots_i[r*COLS + c];
		end
		assign col_pick[c] = col_bits[row_q];
	end

	// only the active row and its columns, only while lit
	always_comb begin
		sink_d = '0;
		col_d = '0;
		if (lit) begin
			sink_d = row_hit;
			col_d = col_pick;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sink_q <= '0;
			col_q <= '0;
		end else begin
			sink_q <= sink_d;
			col_q <= col_d;
		end
	end

	assign row_sink_o = sink_q;
	assign col_src_o = col_q;
	assign peak_current_o = peak_q;
	assign row_index_o = row_q;
	assign refresh_start_o = start_q;
endmodule

// >>> inc/lrs_pkg.sv
package lrs_pkg;
	localparam int ROWS = 8;
	localparam int COLS = 20;
	localparam int DOTS = ROWS * COLS;
	localparam int SLOT_W = 6;
	localparam int ROW_W = 3;
	localparam int ONT_W = 6;
	localparam int PRE_W = 3;
	localparam logic [SLOT_W-1:0] SLOT_LAST = 6'h3f;
	localparam logic [SLOT_W-1:0] BLANK_CYC = 6'h04;
	localparam logic [ONT_W-1:0] ON_MAX = 6'h3c;
	localparam logic [ROW_W-1:0] ROW_LAST = 3'h7;
	localparam logic [PRE_W-1:0] PRE_LAST = 3'h7;
	localparam logic [SLOT_W-1:0] SLOT_RST = 6'h00;
	localparam logic [ROW_W-1:0] ROW_RST = 3'h0;
	localparam logic [PRE_W-1:0] PRE_RST = 3'h0;
	localparam int PEAK_W = 2;
	typedef enum logic [0:0] {
		LRS_BLANK = 1'b0,
		LRS_LIT = 1'b1
	} lrs_phase_t;
endpackage

// >>> tb/lrs_led_model.sv
`timescale 1ns/10ps
module lrs_led_model (
	input wire logic [7:0] row_sink_i,
	output int row_on_o
);
	always_comb begin
		row_on_o = -1;
		for (int r = 0; r < 8; r++) if (row_sink_i[r]) row_on_o = r;
	end
endmodule

// >>> tb/lrs_chk.sv
`timescale 1ns/10ps
module lrs_chk (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] row_sink_o,
	input wire logic [19:0] col_src_o,
	input wire logic [2:0] row_index_o,
	input wire logic refresh_start_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	one_row_a: assert property ($onehot0(row_sink_o)) else $error("rows");
	col_gate_a: assert property (!row_sink_o |-> !col_src_o)
		else $error("columns lit while blank");
	row_step_a: assert property ($changed(row_index_o) |->
		row_index_o - $past(row_index_o) == 3'h1) else $error("row step");
	blank_lead_a: assert property ($changed(row_index_o) |=>
		(row_sink_o == 8'h00) [*4]) else $error("no blanking");
	dark_entry_a: assert property ($changed(row_sink_o) |->
		!row_sink_o || !$past(row_sink_o)) else $error("row overlap");
	start_row_a: assert property (refresh_start_o |-> !row_index_o)
		else $error("start not at row 0");
	pulse_one_a: assert property (refresh_start_o |=> !refresh_start_o)
		else $error("start pulse too long");
	wrap_row_a: assert property ($changed(row_index_o) && !row_index_o |->
		##[0:2] refresh_start_o) else $error("wrap without start");
	cover property (refresh_start_o);
	cover property (row_sink_o == 8'h80);
	cover property (col_src_o != 20'h0);
endmodule
bind lrs_sequencer lrs_chk u_chk (
	.sys_clk_i(sys_clk_i),
	.nrst_i(nrst_i),
	.row_sink_o(row_sink_o),
	.col_src_o(col_src_o),
	.row_index_o(row_index_o),
	.refresh_start_o(refresh_start_o)
);

// >>> tb/lrs_sequencer_bench.sv
`timescale 1ns/10ps
module lrs_sequencer_bench;
	logic sys_clk_i = 0, nrst_i = 0, int_osc_tick_i = 1, ext_osc_tick_i = 0;
	logic ext_osc_select_i = 0, ext_clock_divider_select_i = 0;
	logic [5:0] on_cycles_i = 6'h3c;
	logic [1:0] peak_current_i = 2'h1, peak_current_o;
	logic [159:0] dots_i = 160'h135792468a0fedcba9876543210cab8e3f1d7b92;
	logic [19:0] col_src_o;
	logic [7:0] row_sink_o;
	logic [2:0] row_index_o;
	logic refresh_start_o;
	int bad_count = 0, cmp_count = 0, n, lit, row;
	int ext_gap = 25, ext_cnt = 0;
	lrs_sequencer DUT (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.int_osc_tick_i(int_osc_tick_i),
		.ext_osc_tick_i(ext_osc_tick_i),
		.ext_osc_select_i(ext_osc_select_i),
		.ext_clock_divider_select_i(ext_clock_divider_select_i),
		.on_cycles_i(on_cycles_i),
		.peak_current_i(peak_current_i),
		.dots_i(dots_i),
		.row_sink_o(row_sink_o),
		.col_src_o(col_src_o),
		.peak_current_o(peak_current_o),
		.row_index_o(row_index_o),
		.refresh_start_o(refresh_start_o)
	);
	lrs_led_model led (.row_sink_i(row_sink_o), .row_on_o(row));
	initial forever #20 sys_clk_i = ~sys_clk_i;
	// external oscillator: 1 MHz plain, 6.25 MHz into the prescaler
	initial forever begin
		@(posedge sys_clk_i) #1;
		ext_osc_tick_i = (ext_cnt == 0);
		ext_cnt = (ext_cnt + 1) % ext_gap;
	end
	task chk(string s, logic [31:0] e, logic [31:0] v);
		cmp_count++;
		if (v !== e) begin
			bad_count++;
			$display("wrong value %s expected %0d seen %0d", s, e, v);
		end
	endtask
	task t_run(logic s, logic d, logic [5:0] c, logic [1:0] k, int g, int p,
		int l);
		{ext_osc_select_i, ext_clock_divider_select_i} = {s, d};
		on_cycles_i = c;
		peak_current_i = k;
		ext_gap = g;
		repeat (2) begin
			n = 0;
			lit = 0;
			do begin
				@(posedge sys_clk_i) #1;
				n++;
				lit += row >= 0;
				if (row >= 0) chk("col", dots_i[row*20+:20], col_src_o);
			end while (refresh_start_o !== 1'b1 && n < 20000);
		end
		chk("period", p, n);
		chk("lit", l, lit);
		chk("row at start", 0, row_index_o);
		chk("peak", k, peak_current_o);
		$display("refresh run done");
	endtask
	task final_report;
		$display("checks %0d wrong %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge sys_clk_i);
		#1 nrst_i = 1;
		t_run(0, 0, 6'h3c, 2'h1, 25, 512, 480);
		t_run(1, 0, 6'h01, 2'h2, 25, 12800, 200);
		t_run(1, 1, 6'h3f, 2'h3, 4, 16384, 15360);
		t_run(0, 1, 6'h00, 2'h0, 4, 512, 0);
		final_report;
	end
	initial begin
		#3000000;
		bad_count++;
		final_report;
	end
endmodule
